// ===== testbench/seqnum_set_codec_tb.sv
// Purpose: Self-checking bench for encoder and parser.
// Assumes: A second parser takes hand-made faulty words.
// Notes: A monitor counts pulses; tasks wait on the counts.
`timescale 1ns/1ps
`default_nettype none
module seqnum_set_codec_tb;
  // Element kinds
  localparam snc_pkg::snc_kind_t k_seq = snc_pkg::SNC_K_SEQSET;
  localparam snc_pkg::snc_kind_t k_frag = snc_pkg::SNC_K_FRAGSET;
  localparam snc_pkg::snc_kind_t k_time = snc_pkg::SNC_K_TIME;
  // Clock, reset, encoder request
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic start = 1'h0;
  snc_pkg::snc_kind_t kind = k_seq;
  snc_pkg::snc_kind_t el_kind = k_seq;
  snc_pkg::snc_kind_t ek2 = k_seq;
  logic [63:0] base_number = 64'h0;
  logic [31:0] nbits = 32'h0;
  logic [255:0] bitmap = 256'h0;
  logic [31:0] seconds = 32'h0;
  logic [31:0] fraction = 32'h0;
  logic busy, refused, sent;
  // Parser side
  logic out_ready = 1'h1;
  logic q_valid = 1'h0;
  logic [63:0] q_number = 64'h0;
  logic set_valid, set_is_frag, malformed, time_valid, q_done, q_member;
  logic [63:0] sb, tv;
  logic [8:0] sn;
  logic [255:0] sm;
  logic b_set, b_mal;
  // Event counts, taken words, stall seen
  int n_set, n_time, n_ref, n_sent, n_mal, n_bset, n_busy, n_mbad;
  int mismatches, total_checks;
  logic [32:0] wq[$];
  logic saw_full = 1'h0;
  snc_link_if lnk();
  snc_link_if bad();
  snc_encoder i_snc_encoder (.clk(clk), .rst_n(rst_n), .start(start),
    .kind(kind), .base_number(base_number), .significant_bit_count(nbits),
    .bitmap(bitmap), .seconds(seconds), .fraction(fraction), .busy(busy),
    .refused(refused), .sent(sent), .lnk(lnk.tx));
  snc_parser i_snc_parser (.clk(clk), .rst_n(rst_n), .lnk(lnk.rx),
    .el_kind(el_kind), .out_ready(out_ready), .set_valid(set_valid),
    .set_is_frag(set_is_frag), .set_base_number(sb),
    .significant_bit_count(sn), .set_bitmap(sm), .malformed(malformed),
    .time_valid(time_valid), .time_value(tv), .q_valid(q_valid),
    .q_number(q_number), .q_done(q_done), .q_member(q_member));
  // Second parser fed by the bench with broken messages
  snc_parser i_snc_parser_b (.clk(clk), .rst_n(rst_n), .lnk(bad.rx),
    .el_kind(ek2), .out_ready(1'h1), .set_valid(b_set), .set_is_frag(),
    .set_base_number(), .significant_bit_count(), .set_bitmap(),
    .malformed(b_mal), .time_valid(), .time_value(), .q_valid(1'h0),
    .q_number(64'h0), .q_done(), .q_member());
  snc_link_properties i_snc_link_properties (.clk(clk), .rst_n(rst_n),
    .word(lnk.word), .valid(lnk.valid), .ready(lnk.ready), .last(lnk.last));
  // Clock
  initial forever #5 clk = ~clk;
  // Monitor: counts land one edge after each pulse
  always @(posedge clk) begin
    n_set <= n_set + set_valid;
    n_time <= n_time + time_valid;
    n_ref <= n_ref + refused;
    n_sent <= n_sent + sent;
    n_mal <= n_mal + b_mal;
    n_bset <= n_bset + b_set;
    n_busy <= n_busy + busy;
    n_mbad <= n_mbad + malformed;
    if (lnk.valid && lnk.ready) wq.push_back({lnk.last, lnk.word});
    if (rst_n && !lnk.ready) saw_full <= 1'h1;
  end
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // One request; e is 0 set, 1 time, 2 refused; st stalls the receiver
  task automatic go(input snc_pkg::snc_kind_t k, input logic [63:0] b,
      input logic [31:0] n, input logic [255:0] m, input int e, input int st);
    int s;
    s = n_set + 2 * n_time + 4 * n_ref;
    start <= 1'h1;
    kind <= k;
    el_kind <= k;
    base_number <= b;
    nbits <= n;
    bitmap <= m;
    @(posedge clk);
    start <= 1'h0;
    if (st > 0) begin
      out_ready <= 1'h0;
      repeat (st) @(posedge clk);
      out_ready <= 1'h1;
    end
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      if (n_set + 2 * n_time + 4 * n_ref != s) break;
    end
    chk(n_set + 2 * n_time + 4 * n_ref - s, e == 0 ? 1 : e * 2);
  endtask : go
  // Published set outputs
  task automatic res(input logic f, input logic [63:0] b,
      input logic [8:0] n, input logic [255:0] m);
    chk({set_is_frag, sb, sn}, {f, b, n});
    if (n != 9'h0) chk(sm, m);
  endtask : res
  // Membership query
  task automatic q(input logic [63:0] n, input logic e);
    q_valid <= 1'h1;
    q_number <= n;
    @(posedge clk);
    q_valid <= 1'h0;
    @(posedge clk);
    chk({q_done, q_member}, {1'h1, e});
  endtask : q
  // One word on the faulty link, held until taken
  task automatic push(input logic [31:0] w, input logic l);
    bad.valid <= 1'h1;
    bad.word <= w;
    bad.last <= l;
    do @(posedge clk); while (bad.ready !== 1'h1);
  endtask : push
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    bad.valid = 1'h0;
    bad.word = 32'h0;
    bad.last = 1'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    go(k_seq, 64'h4D2, 32'hC, {32'h3008_0000, 224'h0}, 0, 0);
    chk(n_busy, 4);
    res(1'h0, 64'h4D2, 9'hC, {32'h3008_0000, 224'h0});
    q(64'h4D2, 1'h0);
    q(64'h4D4, 1'h1);
    q(64'h4D5, 1'h1);
    q(64'h4D1, 1'h0);
    q(64'h4DE, 1'h0);
    wq.delete();
    go(k_seq, 64'h2_0000_0010, 32'h28, {32'h8000_0001, 32'h8100_0000,
      192'h0}, 0, 20);
    res(1'h0, 64'h2_0000_0010, 9'h28, {32'h8000_0001, 32'h8100_0000,
      192'h0});
    chk(saw_full, 1'h1);
    chk(wq.size(), 5);
    chk({wq[0], wq[1], wq[2]}, {33'h2, 33'h10, 33'h28});
    chk({wq[3], wq[4]}, {33'h8000_0001, 33'h1_8100_0000});
    q(64'h2_0000_002F, 1'h1);
    q(64'h2_0000_0030, 1'h1);
    q(64'h2_0000_0037, 1'h1);
    q(64'h2_0000_0038, 1'h0);
    q(64'h2_0000_0011, 1'h0);
    go(k_frag, 64'h7, 32'h0, 256'h0, 0, 0);
    res(1'h1, 64'h7, 9'h0, 256'h0);
    q(64'h7, 1'h0);
    go(k_frag, 64'hFFFF_FF00, 32'h100, {8{32'hA5A5_5A5A}}, 0, 0);
    res(1'h1, 64'hFFFF_FF00, 9'h100, {8{32'hA5A5_5A5A}});
    q(64'hFFFF_FF00, 1'h1);
    q(64'hFFFF_FFFE, 1'h1);
    q(64'hFFFF_FFFF, 1'h0);
    wq.delete();
    go(k_seq, 64'h0, 32'h5, 256'h0, 2, 0);
    go(k_seq, {16{4'hF}}, 32'h5, 256'h0, 2, 0);
    go(k_frag, 64'h1_0000_0000, 32'h5, 256'h0, 2, 0);
    go(k_seq, 64'h1, 32'h101, 256'h0, 2, 0);
    chk(wq.size(), 0);
    seconds <= 32'hFFFF_FFFE;
    fraction <= 32'h8000_0000;
    go(k_time, 64'h0, 32'h0, 256'h0, 1, 0);
    chk(tv, 64'hFFFF_FFFE_8000_0000);
    chk(n_sent, 5);
    ek2 <= k_seq;
    push(32'h0, 1'h0);
    push(32'h0, 1'h0);
    push(32'h5, 1'h0);
    push(32'h8000_0000, 1'h1);
    push(32'h0, 1'h0);
    push(32'h9, 1'h0);
    push(32'h28, 1'h0);
    push(32'h1, 1'h1);
    ek2 <= k_frag;
    push(32'h3, 1'h0);
    push(32'h101, 1'h1);
    push(32'h2, 1'h0);
    push(32'h0, 1'h0);
    push(32'h1234_5678, 1'h1);
    ek2 <= k_time;
    push(32'h5, 1'h1);
    bad.valid <= 1'h0;
    repeat (6) @(posedge clk);
    chk(n_mal, 3);
    chk(n_bset, 1);
    chk(n_mbad, 0);
    chk(busy, 1'h0);
    conclude();
  end
endmodule : seqnum_set_codec_tb
`default_nettype wire

// ===== testbench/snc_link_properties.sv
// Purpose: Link checks between the two codec ends.
// Assumes: One clock; rst_n synchronous, active low.
// Notes: wn_q counts words taken within one message.
`timescale 1ns/1ps
`default_nettype none
module snc_link_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link signals
  input wire logic [31:0] word,
  input wire logic valid,
  input wire logic ready,
  input wire logic last
);
  // Words taken so far in this message
  logic [3:0] wn_q;
  logic [3:0] wn_d;
  // Step on each taken word, clear on the final one
  always_comb begin
    wn_d = wn_q;
    if (valid && ready) begin
      wn_d = last ? 4'h0 : wn_q + 4'h1;
    end
  end
  // Counter register
  always_ff @(posedge clk) begin
    wn_q <= rst_n ? wn_d : 4'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_word_held: assert property (
    valid && !ready |=> $stable(word)) else $error("word moved in stall");
  a_valid_held: assert property (
    valid && !ready |=> valid) else $error("valid dropped in stall");
  a_last_held: assert property (
    valid && !ready |=> $stable(last)) else $error("last moved in stall");
  a_reset_idle: assert property (
    $rose(rst_n) |-> ready && !valid) else $error("link busy at reset");
  a_last_min: assert property (
    valid && last |-> wn_q >= 4'h1) else $error("message too short");
  a_len_max: assert property (
    valid |-> wn_q <= 4'hA) else $error("message too long");
  a_gap_after: assert property (
    valid && ready && last |=> !valid) else $error("no gap after last");
  a_full_push: assert property (
    $fell(ready) |-> $past(valid)) else $error("ready fell unpushed");
endmodule : snc_link_properties
`default_nettype wire

// ===== verilog/snc_encoder.sv
// Purpose: Sends one set or timestamp element as a message.
// Assumes: Caller holds inputs steady while start is high.
// Notes: Sets breaking the limits are refused, never sent.
`timescale 1ns/1ps
`default_nettype none
`include "snc_params.svh"
module snc_encoder (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request side
  input wire logic start,
  input wire snc_pkg::snc_kind_t kind,
  input wire logic [63:0] base_number,
  input wire logic [31:0] significant_bit_count,
  input wire logic [255:0] bitmap,
  input wire logic [31:0] seconds,
  input wire logic [31:0] fraction,
  output logic busy,
  output logic refused,
  output logic sent,
  // Link toward the parser
  snc_link_if.tx lnk
);
  // Whole encoder state
  typedef struct packed {
    snc_pkg::snc_estate_t st;
    logic [63:0] base;
    logic [31:0] nbits;
    logic [255:0] bmp;
    logic [31:0] frac;
    logic [3:0] nw;
    logic [3:0] widx;
    logic [31:0] word;
    logic valid;
    logic last;
    logic rej;
    logic done;
  } snc_enc_t;

  snc_enc_t q;
  snc_enc_t d;
  logic ok;
  logic [9:0] nsum;

  // Next state of the encoder
  always_comb begin
    d = q;
    d.rej = 1'b0;
    d.done = 1'b0;
    nsum = 10'(significant_bit_count[8:0]) + `SNC_ROUND_UP;
    ok = (significant_bit_count <= `SNC_MAX_BITS) &&
      ((kind == snc_pkg::SNC_K_FRAGSET) ?
        (base_number[31:0] != 32'h0000_0000) :
        ($signed(base_number) >= $signed(`SNC_BASE_MIN)));
    if (kind == snc_pkg::SNC_K_TIME) begin
      ok = 1'b1;
    end
    case (q.st)
      snc_pkg::SNC_E_IDLE: begin
        if (start && !ok) begin
          d.rej = 1'b1;
        end else if (start) begin
          d.base = base_number;
          d.nbits = significant_bit_count;
          d.bmp = bitmap;
          d.frac = fraction;
          d.nw = nsum[8:5];
          d.widx = 4'h0;
          d.valid = 1'b1;
          d.last = 1'b0;
          if (kind == snc_pkg::SNC_K_TIME) begin
            d.st = snc_pkg::SNC_E_SEC;
            d.word = seconds;
          end else if (kind == snc_pkg::SNC_K_SEQSET) begin
            d.st = snc_pkg::SNC_E_HI;
            d.word = base_number[63:32];
          end else begin
            d.st = snc_pkg::SNC_E_LO;
            d.word = base_number[31:0];
          end
        end
      end
      snc_pkg::SNC_E_HI: begin
        if (lnk.ready) begin
          d.st = snc_pkg::SNC_E_LO;
          d.word = q.base[31:0];
        end
      end
      snc_pkg::SNC_E_LO: begin
        if (lnk.ready) begin
          d.st = snc_pkg::SNC_E_NBITS;
          d.word = q.nbits;
          d.last = (q.nw == 4'h0);
        end
      end
      snc_pkg::SNC_E_NBITS, snc_pkg::SNC_E_BMP: begin
        if (lnk.ready && q.widx == q.nw) begin
          d.st = snc_pkg::SNC_E_IDLE;
          d.valid = 1'b0;
          d.last = 1'b0;
          d.done = 1'b1;
        end else if (lnk.ready) begin
          d.st = snc_pkg::SNC_E_BMP;
          d.word = q.bmp[255:224];
          d.bmp = q.bmp << 32;
          d.widx = q.widx + 4'h1;
          d.last = (q.widx + 4'h1 == q.nw);
        end
      end
      snc_pkg::SNC_E_SEC: begin
        if (lnk.ready) begin
          d.st = snc_pkg::SNC_E_FRAC;
          d.word = q.frac;
          d.last = 1'b1;
        end
      end
      snc_pkg::SNC_E_FRAC: begin
        if (lnk.ready) begin
          d.st = snc_pkg::SNC_E_IDLE;
          d.valid = 1'b0;
          d.last = 1'b0;
          d.done = 1'b1;
        end
      end
      default: begin
        d.st = snc_pkg::SNC_E_IDLE;
        d.valid = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.word = q.word;
  assign lnk.valid = q.valid;
  assign lnk.last = q.last;
  assign busy = (q.st != snc_pkg::SNC_E_IDLE);
  assign refused = q.rej;
  assign sent = q.done;
endmodule : snc_encoder
`default_nettype wire

// ===== verilog/snc_link_if.sv
// Purpose: Word link between encoder and parser.
// Assumes: Both ends share clk; words are 32-bit payload units.
// Notes: last marks the final word of a message.
`timescale 1ns/1ps
`default_nettype none
interface snc_link_if;
  // Payload word, big end first
  logic [31:0] word;
  // Word present
  logic valid;
  // Receiver takes the word
  logic ready;
  // Final word of the message
  logic last;
  modport tx (output word, output valid, output last, input ready);
  modport rx (input word, input valid, input last, output ready);
endinterface : snc_link_if
`default_nettype wire

// ===== verilog/snc_params.svh
// Purpose: Constants of the sequence-number-set codec.
// Assumes: Included by bare name from the encoder and the parser.
// Notes: Offsets, limits and widths only; no logic here.
`ifndef SNC_PARAMS_SVH
`define SNC_PARAMS_SVH
// Most bits one set may describe
`define SNC_MAX_BITS 32'h0000_0100
// Rounding term for the bitmap word count
`define SNC_ROUND_UP 10'h01F
// Smallest legal base number
`define SNC_BASE_MIN 64'h0000_0000_0000_0001
// Top bit index of the bitmap store
`define SNC_BMP_TOP 8'hFF
// Width of the zero tail behind the first bitmap word
`define SNC_TAIL_W 224
`endif

// ===== verilog/snc_parser.sv
// Purpose: Parses one set or timestamp element per message.
// Assumes: Message end comes only from the link's last flag.
// Notes: A two-entry buffer absorbs words while out_ready is low.
`timescale 1ns/1ps
`default_nettype none
`include "snc_params.svh"
module snc_parser (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link from the encoder
  snc_link_if.rx lnk,
  // Element kind expected in each message
  input wire snc_pkg::snc_kind_t el_kind,
  // Receiver stall: low holds words in the buffer
  input wire logic out_ready,
  // Parsed set
  output logic set_valid,
  output logic set_is_frag,
  output logic [63:0] set_base_number,
  output logic [8:0] significant_bit_count,
  output logic [255:0] set_bitmap,
  output logic malformed,
  // Parsed timestamp, 32.32 signed fixed point
  output logic time_valid,
  output logic [63:0] time_value,
  // Membership query
  input wire logic q_valid,
  input wire logic [63:0] q_number,
  output logic q_done,
  output logic q_member
);
  // Whole parser state
  typedef struct packed {
    snc_pkg::snc_pstate_t st;
    snc_pkg::snc_kind_t kind;
    logic [1:0][32:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic [63:0] base;
    logic [8:0] nbits;
    logic [3:0] widx;
    logic [255:0] bmp;
    logic [31:0] sec;
    logic [31:0] frac;
    logic frag_o;
    logic [63:0] base_o;
    logic [8:0] nbits_o;
    logic [255:0] bmp_o;
    logic setv;
    logic bad;
    logic timev;
    logic qd;
    logic qm;
  } snc_par_t;

  snc_par_t q;
  snc_par_t d;
  // Buffer handshakes
  logic push;
  logic pop;
  // Word at the buffer head
  logic [31:0] w;
  logic lst;
  // Per-word decisions
  logic done_now;
  logic bad_now;
  logic base_ok;
  snc_pkg::snc_pstate_t nx;
  // Bitmap word count and query terms
  logic [9:0] nsum;
  logic [63:0] qoff;
  logic in_lo;

  // Buffer accepts while a slot is free
  assign lnk.ready = (q.cnt != 2'h2);

  // Next state of the parser
  always_comb begin
    d = q;
    d.setv = 1'b0;
    d.bad = 1'b0;
    d.timev = 1'b0;
    d.qd = 1'b0;
    done_now = 1'b0;
    bad_now = 1'b0;
    nx = q.st;
    // Two-entry buffer in the word path
    push = lnk.valid && (q.cnt != 2'h2);
    pop = (q.cnt != 2'h0) && out_ready;
    w = q.mem[q.rp][31:0];
    lst = q.mem[q.rp][32];
    if (push) begin
      d.mem[q.wp] = {lnk.last, lnk.word};
      d.wp = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    nsum = 10'(q.nbits) + `SNC_ROUND_UP;
    if (q.kind == snc_pkg::SNC_K_FRAGSET) begin
      base_ok = (q.base[31:0] != 32'h0000_0000);
    end else begin
      base_ok = ($signed(q.base) >= $signed(`SNC_BASE_MIN));
    end
    if (pop) begin
      case (q.st)
        snc_pkg::SNC_P_HEAD: begin
          d.kind = el_kind;
          if (el_kind == snc_pkg::SNC_K_TIME) begin
            d.sec = w;
            nx = snc_pkg::SNC_P_TFRAC;
          end else if (el_kind == snc_pkg::SNC_K_SEQSET) begin
            d.base = {w, 32'h0000_0000};
            nx = snc_pkg::SNC_P_LO;
          end else begin
            d.base = {32'h0000_0000, w};
            nx = snc_pkg::SNC_P_NBITS;
          end
        end
        snc_pkg::SNC_P_LO: begin
          d.base = {q.base[63:32], w};
          nx = snc_pkg::SNC_P_NBITS;
        end
        snc_pkg::SNC_P_NBITS: begin
          d.nbits = w[8:0];
          d.bmp = '0;
          d.widx = 4'h0;
          if (w > `SNC_MAX_BITS || !base_ok) begin
            bad_now = 1'b1;
          end else if (w == 32'h0000_0000) begin
            done_now = 1'b1;
          end else begin
            nx = snc_pkg::SNC_P_BMP;
          end
        end
        // word k lands at top minus 32k
        snc_pkg::SNC_P_BMP: begin
          d.bmp = q.bmp | ({w, `SNC_TAIL_W'(0)} >> {q.widx, 5'h00});
          d.widx = q.widx + 4'h1;
          if (q.widx + 4'h1 == nsum[8:5]) begin
            done_now = 1'b1;
          end
        end
        snc_pkg::SNC_P_TFRAC: begin
          d.frac = w;
          done_now = 1'b1;
        end
        snc_pkg::SNC_P_SKIP: begin
          if (lst) begin
            nx = snc_pkg::SNC_P_HEAD;
          end
        end
        default: begin
          nx = snc_pkg::SNC_P_HEAD;
        end
      endcase
      if (bad_now) begin
        d.bad = 1'b1;
        d.st = lst ? snc_pkg::SNC_P_HEAD : snc_pkg::SNC_P_SKIP;
      end else if (done_now) begin
        if (q.kind == snc_pkg::SNC_K_TIME) begin
          d.timev = 1'b1;
        end else begin
          d.setv = 1'b1;
          d.frag_o = (q.kind == snc_pkg::SNC_K_FRAGSET);
          d.base_o = q.base;
          d.nbits_o = d.nbits;
          d.bmp_o = d.bmp;
        end
        d.st = lst ? snc_pkg::SNC_P_HEAD : snc_pkg::SNC_P_SKIP;
      end else if (lst && q.st != snc_pkg::SNC_P_SKIP) begin
        // message ends before its last word
        // At the head the new kind decides, later the stored one
        if (q.st == snc_pkg::SNC_P_HEAD) begin
          d.bad = (el_kind != snc_pkg::SNC_K_TIME);
        end else begin
          d.bad = (q.kind != snc_pkg::SNC_K_TIME);
        end
        d.st = snc_pkg::SNC_P_HEAD;
      end else begin
        d.st = nx;
      end
    end
    qoff = q_number - q.base_o;
    if (q.frag_o) begin
      in_lo = (q_number[31:0] >= q.base_o[31:0]) &&
        (q_number[63:32] == 32'h0000_0000);
    end else begin
      in_lo = ($signed(q_number) >= $signed(q.base_o));
    end
    if (q_valid) begin
      d.qd = 1'b1;
      d.qm = in_lo && (qoff < 64'(q.nbits_o)) &&
        q.bmp_o[`SNC_BMP_TOP - qoff[7:0]];
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // published set up to 256 bits
  assign set_valid = q.setv;
  assign set_is_frag = q.frag_o;
  assign set_base_number = q.base_o;
  assign significant_bit_count = q.nbits_o;
  assign set_bitmap = q.bmp_o;
  assign malformed = q.bad;
  assign time_valid = q.timev;
  assign time_value = {q.sec, q.frac};
  assign q_done = q.qd;
  assign q_member = q.qm;
endmodule : snc_parser
`default_nettype wire

// ===== verilog/snc_pkg.sv
// Purpose: Types shared by both ends of the set codec.
// Assumes: Nothing beyond the constants header.
// Notes: Element kinds and state codes of both ends.
`default_nettype none
package snc_pkg;
  // Element kind carried by one message
  typedef enum logic [1:0] {
    SNC_K_SEQSET = 2'h0,
    SNC_K_FRAGSET = 2'h1,
    SNC_K_TIME = 2'h2
  } snc_kind_t;

  // Parser states, named by the word expected next
  typedef enum logic [2:0] {
    SNC_P_HEAD = 3'h0,
    SNC_P_LO = 3'h1,
    SNC_P_NBITS = 3'h2,
    SNC_P_BMP = 3'h3,
    SNC_P_TFRAC = 3'h4,
    SNC_P_SKIP = 3'h5
  } snc_pstate_t;

  // Encoder states, named by the word on the link
  typedef enum logic [2:0] {
    SNC_E_IDLE = 3'h0,
    SNC_E_HI = 3'h1,
    SNC_E_LO = 3'h2,
    SNC_E_NBITS = 3'h3,
    SNC_E_BMP = 3'h4,
    SNC_E_SEC = 3'h5,
    SNC_E_FRAC = 3'h6
  } snc_estate_t;
endpackage : snc_pkg
`default_nettype wire
